/* File: design/pic_regs.vh */
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// Fixed vector numbers of the exception slots.
`define PIC_VEC_RESET 5'h00
`define PIC_VEC_MISALIGN 5'h01
`define PIC_VEC_NMI 5'h02
`define PIC_VEC_COMPILER 5'h03

// First maskable vector; maskable slot y carries vector y plus this value.
`define PIC_VEC_FIRST_MASKABLE 5'h04
`define PIC_VEC_LAST_USED 5'h17
`define PIC_VEC_LAST 5'h1f

// Maskable slot whose vector (6) is reserved.
`define PIC_RSV_SLOT 2

// Byte offsets of the fixed handler entries from the table base.
`define PIC_OFS_RESET 24'h000000
`define PIC_OFS_NMI 24'h000008
`define PIC_OFS_COMPILER 24'h00000c

// Vector table base: bits 23:8 are stored, bits 7:0 read as zero.
`define PIC_BASE_RESET 16'h0080
`define PIC_BASE_LOW_BITS 8'h00
`define PIC_BASE_MID_RESET 8'h80
`define PIC_BASE_HIGH_RESET 8'h00

// System protect key that opens the protected registers.
`define PIC_PROT_KEY 16'h0096
`define PIC_PROT_RESET 16'h0000

// Level setup register layout: even slot in 2:0, odd slot in 10:8.
`define PIC_LVL_EVEN_LSB 0
`define PIC_LVL_ODD_LSB 8
`define PIC_LVL_W 3
`define PIC_LVL_RESET 3'h0
`define PIC_LVL_NONE 3'h0

`endif

/* File: design/pic_cause_cell.v */
`timescale 1ns/10ps
`default_nettype none

// Flag and enable pairs of one interrupt source, one pair per cause.
module pic_cause_cell #(
	parameter NC = 4
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Cause events and software access
	input wire [NC-1:0] cause_set,
	input wire [NC-1:0] flag_clr,
	input wire enable_we,
	input wire [NC-1:0] enable_wdata,
	// State
	output wire [NC-1:0] flag,
	output wire [NC-1:0] enable,
	output wire req
);

	reg [NC-1:0] flag_r;
	reg [NC-1:0] enable_r;

	// A cause arriving in the clearing cycle keeps the flag set.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			flag_r <= {NC{1'b0}};
		end else begin
			flag_r <= cause_set | (flag_r & ~flag_clr);
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			enable_r <= {NC{1'b0}};
		end else if (enable_we) begin
			enable_r <= enable_wdata;
		end
	end

	// Level request: enabling over a set flag requests at once.
	assign req = |(flag_r & enable_r);
	assign flag = flag_r;
	assign enable = enable_r;

endmodule // pic_cause_cell

`default_nettype wire

/* File: design/pic_level_bank.v */
`timescale 1ns/10ps
`default_nettype none

`include "pic_regs.vh"

// Source level setup registers, two slots per register.
module pic_level_bank #(
	parameter NS = 20
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Software access
	input wire level_we,
	input wire [3:0] level_idx,
	input wire [15:0] level_wdata,
	output reg [15:0] level_rdata,
	// Levels of all slots, slot y in bits 3y+2:3y
	output wire [NS*3-1:0] levels
);

	localparam NREG = (NS + 1) / 2;

	reg [NS*3-1:0] lvl_r;
	reg [15:0] rd_nxt;
	integer k;
	integer j;

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lvl_r <= {NS{`PIC_LVL_RESET}};
		end else if (level_we && level_idx < NREG) begin
			for (k = 0; k < NS; k = k + 1) begin
				if (k / 2 == level_idx && k != `PIC_RSV_SLOT) begin
					if (k % 2 == 0) begin
						lvl_r[k*3 +: 3] <= level_wdata[`PIC_LVL_EVEN_LSB +: `PIC_LVL_W];
					end else begin
						lvl_r[k*3 +: 3] <= level_wdata[`PIC_LVL_ODD_LSB +: `PIC_LVL_W];
					end
				end
			end
		end
	end

	always @* begin
		rd_nxt = 16'h0000;
		for (j = 0; j < NS; j = j + 1) begin
			if (j / 2 == level_idx) begin
				if (j % 2 == 0) begin
					rd_nxt[`PIC_LVL_EVEN_LSB +: `PIC_LVL_W] = lvl_r[j*3 +: 3];
				end else begin
					rd_nxt[`PIC_LVL_ODD_LSB +: `PIC_LVL_W] = lvl_r[j*3 +: 3];
				end
			end
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			level_rdata <= 16'h0000;
		end else begin
			level_rdata <= rd_nxt;
		end
	end

	assign levels = lvl_r;

endmodule // pic_level_bank

`default_nettype wire

/* File: design/pic_interrupt_arbiter.v */
`timescale 1ns/10ps
`default_nettype none

`include "pic_regs.vh"

// What this block does
// - Drive request, level and vector of the winning source to the core.
// - Each maskable source has a programmable three-bit level, 0 low, 7 high.
// - Among pending requests the highest level wins.
// - On equal levels the smallest vector number wins.
// - Vector numbers are fixed per source; 6 and 24 to 31 reserved.
// - Handler address is table base plus four times the vector.
// - Vectors 0 to 3 are reset, misalignment, NMI and compiler slot.
// - The table base is 0x8000 after reset.
// - The low eight base bits are always zero.
// - Levels reset to 0 and a level 0 request is never offered.
// - One flag and one enable bit for every cause.
// - A flag goes to 1 whenever its cause occurs.
// - A request is forwarded only while flag and enable are both 1.
// - Enabling while the flag is already 1 requests at once.
// - Watchdog overflow goes to reset or to NMI by software choice.
// - A newer higher-priority cause replaces the offered one; the older stays pending.
// - Clearing the flag of a pending request drops it without interrupt.
module pic_interrupt_arbiter #(
	parameter NS = 20,
	parameter NC = 4
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Peripheral causes and their flag and enable access
	input wire [NS*NC-1:0] cause_set,
	input wire [NS*NC-1:0] flag_clr,
	input wire [NS-1:0] enable_we,
	input wire [NS*NC-1:0] enable_wdata,
	output wire [NS*NC-1:0] flag_state,
	output wire [NS*NC-1:0] enable_state,
	// Source level setup registers
	input wire level_we,
	input wire [3:0] level_idx,
	input wire [15:0] level_wdata,
	output wire [15:0] level_rdata,
	// System protect register
	input wire protect_we,
	input wire [15:0] protect_wdata,
	output wire [15:0] protect_rdata,
	output wire protect_open,
	// Vector table base registers
	input wire base_low_we,
	input wire [15:0] base_low_wdata,
	output wire [15:0] base_low_rdata,
	input wire base_high_we,
	input wire [15:0] base_high_wdata,
	output wire [15:0] base_high_rdata,
	// Watchdog routing
	input wire wdt_route_we,
	input wire wdt_route_wdata,
	output wire wdt_route_nmi,
	input wire wdt_overflow,
	output reg nmi_req,
	output reg wdt_reset_req,
	// Request toward the processor core
	output reg irq_req,
	output reg [2:0] irq_level,
	output reg [4:0] irq_vector,
	output reg [23:0] irq_handler_addr,
	output reg [23:0] nmi_handler_addr,
	output reg [23:0] reset_handler_addr
);

	wire [NS-1:0] slot_req;
	wire [NS*3-1:0] levels;

	reg [15:0] protect_r;
	reg [7:0] base_mid_r;
	reg [7:0] base_high_r;
	reg wdt_route_r;

	reg win_hit_nxt;
	reg [2:0] win_lvl_nxt;
	reg [4:0] win_vec_nxt;
	reg [2:0] top_lvl_nxt;
	reg [4:0] scan_vec;
	integer i;
	integer j;

	wire [NS-1:0] slot_elig;

	wire [23:0] table_base;
	wire [23:0] win_addr_nxt;

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_src
			pic_cause_cell #(
				.NC(NC)
			) pic_cause_cell_inst (
				.sys_clk(sys_clk),
				.reset(reset),
				.cause_set(cause_set[g*NC +: NC]),
				.flag_clr(flag_clr[g*NC +: NC]),
				.enable_we(enable_we[g]),
				.enable_wdata(enable_wdata[g*NC +: NC]),
				.flag(flag_state[g*NC +: NC]),
				.enable(enable_state[g*NC +: NC]),
				.req(slot_req[g])
			);
		end
	endgenerate

	pic_level_bank #(
		.NS(NS)
	) pic_level_bank_inst (
		.sys_clk(sys_clk),
		.reset(reset),
		.level_we(level_we),
		.level_idx(level_idx),
		.level_wdata(level_wdata),
		.level_rdata(level_rdata),
		.levels(levels)
	);

	// The protect register holds whatever was written; only the key opens.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			protect_r <= `PIC_PROT_RESET;
		end else if (protect_we) begin
			protect_r <= protect_wdata;
		end
	end

	assign protect_open = (protect_r == `PIC_PROT_KEY);
	assign protect_rdata = protect_r;

	// Base writes are dropped silently while protection is closed.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			base_mid_r <= `PIC_BASE_MID_RESET;
		end else if (base_low_we && protect_open) begin
			base_mid_r <= base_low_wdata[15:8];
		end
	end

	// The high byte has its own write strobe, so a half-written base is possible.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			base_high_r <= `PIC_BASE_HIGH_RESET;
		end else if (base_high_we && protect_open) begin
			base_high_r <= base_high_wdata[7:0];
		end
	end

	assign table_base = {base_high_r, base_mid_r, `PIC_BASE_LOW_BITS};
	assign base_low_rdata = {base_mid_r, `PIC_BASE_LOW_BITS};
	assign base_high_rdata = {8'h00, base_high_r};

	// The route bit is plain so a test can flip it without protection.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wdt_route_r <= 1'b0;
		end else if (wdt_route_we) begin
			wdt_route_r <= wdt_route_wdata;
		end
	end

	assign wdt_route_nmi = wdt_route_r;

	// The route is taken in the overflow cycle, so one event never goes both ways.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			nmi_req <= 1'b0;
		end else begin
			nmi_req <= wdt_overflow & wdt_route_r;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wdt_reset_req <= 1'b0;
		end else begin
			wdt_reset_req <= wdt_overflow & ~wdt_route_r;
		end
	end

	// A slot competes only with a live request and a nonzero level.
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_elig
			assign slot_elig[g] = slot_req[g] && (levels[g*3 +: 3] != `PIC_LVL_NONE);
		end
	endgenerate

	// First pass finds the highest level on offer.
	always @* begin
		top_lvl_nxt = `PIC_LVL_NONE;
		for (i = 0; i < NS; i = i + 1) begin
			if (slot_elig[i] && levels[i*3 +: 3] > top_lvl_nxt) begin
				top_lvl_nxt = levels[i*3 +: 3];
			end
		end
	end

	// Second pass takes the first slot at that level, which has the smallest vector.
	always @* begin
		win_hit_nxt = 1'b0;
		win_lvl_nxt = `PIC_LVL_NONE;
		win_vec_nxt = `PIC_VEC_RESET;
		scan_vec = `PIC_VEC_FIRST_MASKABLE;
		for (j = 0; j < NS; j = j + 1) begin
			if (!win_hit_nxt && slot_elig[j] && levels[j*3 +: 3] == top_lvl_nxt) begin
				win_hit_nxt = 1'b1;
				win_lvl_nxt = top_lvl_nxt;
				win_vec_nxt = scan_vec;
			end
			scan_vec = scan_vec + 5'h01;
		end
	end

	assign win_addr_nxt = table_base + {17'h00000, win_vec_nxt, 2'b00};

	// Re-evaluated every cycle, so a newer winner or a cleared flag shows next edge.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= win_hit_nxt;
		end
	end

	// Idle level, vector and address read zero, so a dropped winner never lingers.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_level <= `PIC_LVL_NONE;
		end else begin
			irq_level <= win_hit_nxt ? win_lvl_nxt : `PIC_LVL_NONE;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_vector <= `PIC_VEC_RESET;
		end else begin
			irq_vector <= win_hit_nxt ? win_vec_nxt : `PIC_VEC_RESET;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_handler_addr <= 24'h000000;
		end else begin
			irq_handler_addr <= win_hit_nxt ? win_addr_nxt : 24'h000000;
		end
	end

	// Fixed exception entries follow the base.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			nmi_handler_addr <= 24'h000000;
		end else begin
			nmi_handler_addr <= table_base + `PIC_OFS_NMI;
		end
	end

	// The reset entry lags a base write by one cycle, like every other entry.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reset_handler_addr <= 24'h000000;
		end else begin
			reset_handler_addr <= table_base + `PIC_OFS_RESET;
		end
	end

endmodule // pic_interrupt_arbiter

`default_nettype wire

/* File: bench/pic_arb_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_arb_asserts #(parameter NS = 20, parameter NC = 4) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Observed ports
	input wire [NS*NC-1:0] flag_state,
	input wire [NS*NC-1:0] enable_state,
	input wire irq_req,
	input wire [2:0] irq_level,
	input wire [4:0] irq_vector,
	input wire [23:0] irq_handler_addr,
	input wire [23:0] nmi_handler_addr,
	input wire [15:0] base_low_rdata,
	input wire [15:0] base_high_rdata,
	input wire [15:0] protect_rdata,
	input wire protect_open,
	input wire wdt_overflow,
	input wire wdt_route_nmi,
	input wire nmi_req,
	input wire wdt_reset_req
);
	wire [23:0] base = {base_high_rdata[7:0], base_low_rdata};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_level_not_zero: assert property (irq_req |-> irq_level != 3'h0) else $error("level zero offered");
	a_vector_legal: assert property (irq_req |-> irq_vector inside {[5'h04:5'h17]} && irq_vector != 5'h06)
		else $error("illegal vector");
	a_handler_addr: assert property (irq_req && $stable(base) |-> irq_handler_addr == base + {17'h0, irq_vector, 2'b00})
		else $error("handler address wrong");
	a_nmi_addr: assert property (!$past(reset) && $stable(base) |-> nmi_handler_addr == base + 24'h000008)
		else $error("nmi address wrong");
	a_base_aligned: assert property (base[7:0] == 8'h00) else $error("base not aligned");
	a_key_opens: assert property (protect_open == (protect_rdata == 16'h0096)) else $error("protect decode wrong");
	a_req_gated: assert property (irq_req |-> $past(|(flag_state & enable_state))) else $error("request without cause");
	a_wdt_route: assert property (wdt_overflow |=> nmi_req == $past(wdt_route_nmi) && wdt_reset_req != $past(wdt_route_nmi))
		else $error("watchdog routed wrong");
	a_idle_clear: assert property (!irq_req |-> irq_level == 3'h0 && irq_vector == 5'h00 && irq_handler_addr == 24'h0)
		else $error("idle outputs not zero");
endmodule // pic_arb_asserts
`default_nettype wire

/* File: bench/pic_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Request and core state
	input wire irq_req,
	input wire [2:0] irq_level,
	input wire cpu_interrupt_enable,
	input wire [2:0] cpu_current_level,
	output logic accept_r
);
	// Acceptance is only observed; the core has no acknowledge wire into the block.
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			accept_r <= 1'b0;
		else
			accept_r <= irq_req && cpu_interrupt_enable && irq_level > cpu_current_level;
	end
endmodule // pic_cpu_model
`default_nettype wire

/* File: bench/pic_interrupt_arbiter_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, o) begin checked++; if ((o) !== (e)) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, o); end end
module pic_interrupt_arbiter_bench;
	typedef struct packed {integer sel; logic [47:0] v;} pic_note_t;
	reg sys_clk = 0, reset = 1, level_we = 0, protect_we = 0, base_low_we = 0, base_high_we = 0;
	reg wdt_route_we = 0, wdt_route_wdata = 0, wdt_overflow = 0, ie = 1;
	reg [79:0] cause_set = 0, flag_clr = 0, enable_wdata = 0, fl = 0, en = 0;
	reg [19:0] enable_we = 0;
	reg [3:0] level_idx = 0;
	reg [15:0] level_wdata = 0, protect_wdata = 0, base_low_wdata = 0, base_high_wdata = 0;
	reg [2:0] lv [0:19];
	reg [2:0] cur = 0;
	reg [23:0] bs = 24'h008000;
	wire [79:0] flag_state, enable_state;
	wire [15:0] level_rdata, protect_rdata, base_low_rdata, base_high_rdata;
	wire protect_open, wdt_route_nmi, nmi_req, wdt_reset_req, irq_req, accept_r;
	wire [2:0] irq_level;
	wire [4:0] irq_vector;
	wire [23:0] irq_handler_addr, nmi_handler_addr, reset_handler_addr;
	integer error_cnt = 0, checked = 0, cycles = 0, seed = 32'h5571c94d, i, r;
	string nm [0:4] = '{"irq", "handler", "accept", "base", "wdt"};
	pic_note_t q [$];
	pic_note_t e;
	pic_interrupt_arbiter pic_interrupt_arbiter_inst (.sys_clk(sys_clk), .reset(reset), .cause_set(cause_set),
		.flag_clr(flag_clr), .enable_we(enable_we), .enable_wdata(enable_wdata), .flag_state(flag_state),
		.enable_state(enable_state), .level_we(level_we), .level_idx(level_idx), .level_wdata(level_wdata),
		.level_rdata(level_rdata), .protect_we(protect_we), .protect_wdata(protect_wdata),
		.protect_rdata(protect_rdata), .protect_open(protect_open), .base_low_we(base_low_we),
		.base_low_wdata(base_low_wdata), .base_low_rdata(base_low_rdata), .base_high_we(base_high_we),
		.base_high_wdata(base_high_wdata), .base_high_rdata(base_high_rdata), .wdt_route_we(wdt_route_we),
		.wdt_route_wdata(wdt_route_wdata), .wdt_route_nmi(wdt_route_nmi), .wdt_overflow(wdt_overflow),
		.nmi_req(nmi_req), .wdt_reset_req(wdt_reset_req), .irq_req(irq_req), .irq_level(irq_level),
		.irq_vector(irq_vector), .irq_handler_addr(irq_handler_addr), .nmi_handler_addr(nmi_handler_addr),
		.reset_handler_addr(reset_handler_addr));
	pic_cpu_model pic_cpu_model_inst (.sys_clk(sys_clk), .reset(reset), .irq_req(irq_req), .irq_level(irq_level),
		.cpu_interrupt_enable(ie), .cpu_current_level(cur), .accept_r(accept_r));
	initial forever #20 sys_clk = ~sys_clk;
	// Reference winner: a strict compare in ascending slot order keeps the lowest vector on ties.
	function [47:0] want(input integer sel);
		integer s;
		reg [2:0] bl;
		reg [4:0] bv;
		begin
			bl = 0;
			bv = 0;
			for (s = 0; s < 20; s++)
				if (s != 2 && lv[s] > bl && |(fl[s*4+:4] & en[s*4+:4])) begin
					bl = lv[s];
					bv = 5'(s + 4);
				end
			case (sel)
				0: want = {bl != 0, bl, bv, (bl != 0) ? bs + {bv, 2'b00} : 24'h0};
				1: want = {bs + 24'h000008, bs};
				default: want = {47'h0, bl != 0 && ie && bl > cur};
			endcase
		end
	endfunction
	function [47:0] seen(input integer sel);
		case (sel)
			0: seen = {irq_req, irq_level, irq_vector, irq_handler_addr};
			1: seen = {nmi_handler_addr, reset_handler_addr};
			2: seen = {47'h0, accept_r};
			3: seen = {base_high_rdata, base_low_rdata};
			default: seen = {nmi_req, wdt_reset_req};
		endcase
	endfunction
	task note(input integer n, input integer sel, input [47:0] v);
		begin
			if (n > 0) begin
				repeat (n) @(posedge sys_clk);
				#1;
			end
			q.push_back('{sel, v});
		end
	endtask
	task drv(input integer op, input integer s, input integer c, input [15:0] d);
		begin
			@(posedge sys_clk);
			#1;
			case (op)
				0: begin cause_set[s*4+c] = 1; fl[s*4+c] = 1; end
				1: begin flag_clr[s*4+c] = 1; fl[s*4+c] = 0; end
				2: begin enable_we[s] = 1; enable_wdata[s*4+:4] = d[3:0]; en[s*4+:4] = d[3:0]; end
				3: begin level_we = 1; level_idx = s[3:0]; level_wdata = d; lv[2*s] = d[2:0]; lv[2*s+1] = d[10:8]; end
				4: begin protect_we = 1; protect_wdata = d; end
				5: begin base_low_we = 1; base_low_wdata = d; if (protect_wdata == 16'h0096) bs[15:8] = d[15:8]; end
				6: begin base_high_we = 1; base_high_wdata = d; if (protect_wdata == 16'h0096) bs[23:16] = d[7:0]; end
				7: begin wdt_route_we = 1; wdt_route_wdata = d[0]; end
				default: wdt_overflow = 1;
			endcase
			@(posedge sys_clk);
			#1;
			cause_set = 0;
			flag_clr = 0;
			enable_we = 0;
			{level_we, protect_we, base_low_we, base_high_we, wdt_route_we, wdt_overflow} = 6'h00;
		end
	endtask
	task end_sim;
		begin
			$display("checked %0d error_cnt %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(negedge sys_clk) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			`CHK(nm[e.sel], e.v, seen(e.sel))
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		for (i = 0; i < 20; i++)
			lv[i] = 0;
		repeat (4) @(posedge sys_clk);
		#1;
		reset = 0;
		note(0, 3, 48'h000000008000);
		note(2, 1, want(1));
		drv(0, 1, 0, 0);
		drv(2, 1, 0, 16'h0001);
		note(2, 0, want(0));
		drv(3, 1, 0, 16'h0503);
		drv(3, 0, 0, 16'h0303);
		drv(0, 3, 1, 0);
		note(2, 0, want(0));
		drv(2, 3, 0, 16'h0002);
		note(2, 0, want(0));
		note(0, 0, want(0));
		drv(0, 0, 2, 0);
		drv(2, 0, 0, 16'h0004);
		drv(2, 2, 0, 16'h000f);
		drv(0, 2, 0, 0);
		drv(1, 3, 1, 0);
		note(2, 0, want(0));
		drv(5, 0, 0, 16'h4100);
		note(2, 3, {16'h0, bs[23:8], 8'h00});
		drv(4, 0, 0, 16'h0096);
		drv(5, 0, 0, 16'($random(seed)));
		drv(6, 0, 0, 16'($random(seed)));
		drv(4, 0, 0, 16'h0000);
		drv(6, 0, 0, 16'h00ff);
		note(2, 3, {16'h0, bs[23:8], 8'h00});
		note(0, 1, want(1));
		for (i = 0; i < 10; i++)
			drv(3, i, 0, 16'($random(seed) & 16'h0707));
		for (i = 0; i < 60; i++) begin
			cur = 3'($random(seed));
			ie = 1'($random(seed));
			r = $unsigned($random(seed)) % 3;
			drv(r, $unsigned($random(seed)) % 20, $unsigned($random(seed)) % 4, 16'($random(seed)));
			note(2, 0, want(0));
			note(1, 2, want(2));
		end
		drv(2, 19, 0, 16'h0000);
		drv(3, 9, 0, 16'h0700);
		drv(0, 19, 3, 0);
		drv(1, 19, 3, 0);
		drv(2, 19, 0, 16'h0008);
		drv(0, 19, 3, 0);
		note(2, 0, want(0));
		drv(1, 19, 3, 0);
		note(2, 0, want(0));
		for (i = 0; i < 2; i++) begin
			drv(7, 0, 0, 16'(i));
			drv(8, 0, 0, 0);
			note(0, 4, {46'h0, i[0], ~i[0]});
		end
		repeat (3) @(posedge sys_clk);
		end_sim;
	end
endmodule // pic_interrupt_arbiter_bench
bind pic_interrupt_arbiter pic_arb_asserts #(.NS(NS), .NC(NC)) pic_arb_asserts_inst (.sys_clk(sys_clk), .reset(reset),
	.flag_state(flag_state), .enable_state(enable_state), .irq_req(irq_req), .irq_level(irq_level),
	.irq_vector(irq_vector), .irq_handler_addr(irq_handler_addr), .nmi_handler_addr(nmi_handler_addr),
	.base_low_rdata(base_low_rdata), .base_high_rdata(base_high_rdata), .protect_rdata(protect_rdata),
	.protect_open(protect_open), .wdt_overflow(wdt_overflow), .wdt_route_nmi(wdt_route_nmi), .nmi_req(nmi_req),
	.wdt_reset_req(wdt_reset_req));
`default_nettype wire
